//--- rtl/ext_cap_config.v
// Our own choices: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`include "ext_cap_consts.vh"

// Notes on behaviour
// - vc and vendor caps need serial capability
// - vc cap: any class maps to vc0, filtered
// - root port snoop rejection flags unsupported request
// - legacy user space forwards beyond built-in range
// - legacy pointer limited to 2A..3F dwords
// - extended requests at or above pointer forwarded
// - header log holds one header only
// - root status, source id zero without permission
// - unsupported optional error bits read zero
// - ecrc mode 0 never, 1 always, 3 if enabled
// - trimming clears td and strips digest
// - disable poisoned response suppresses automatic reporting
// - advisory mask: poisoned cfg write gets ur, parity
// - advisory mask: poisoned mem write sets parity, no ur or message
// - no mask, enabled: poisoned mem write sends message
// - no mask, disabled: no automatic message
// - user poison report then sends message
// - resizable_bar_capability entries: size vector and bar index
// - resizable_bar_capability size resets to initial value
module ext_cap_config
(
    input wire i_clk,
    input wire i_rst,
    input wire i_psel,
    input wire i_penable,
    input wire i_pwrite,
    input wire [11:0] i_paddr,
    input wire [31:0] i_pwdata,
    output wire o_pready,
    output reg [31:0] o_prdata,
    output wire o_pslverr,
    input wire [63:0] i_serial_number,
    input wire i_rx_valid,
    input wire i_rx_is_cfg,
    input wire i_rx_is_cfgwr,
    input wire i_rx_is_memwr,
    input wire i_rx_ext_space,
    input wire [9:0] i_rx_dw_addr,
    input wire [2:0] i_rx_tc,
    input wire i_rx_snoop_applies,
    input wire i_rx_no_snoop,
    input wire i_rx_td,
    input wire i_rx_poisoned,
    input wire i_rx_ecrc_bad,
    input wire [31:0] i_rx_header,
    input wire i_poison_report,
    output reg o_fwd_to_user,
    output reg o_ur_completion,
    output reg o_ecrc_error,
    output reg o_rx_td,
    output reg o_strip_digest,
    output reg o_err_msg,
    output reg [2:0] o_vc_tc,
    output reg [63:0] o_serial_number
);

// ==========================================================
// register state
// ==========================================================
reg [7:0] cap_ctrl;
reg [5:0] leg_ptr;
reg [9:0] ext_ptr;
reg [5:0] ecrc_ctrl;
reg [31:0] err_opt;
reg [31:0] root_stat;
reg [31:0] src_id;
reg [31:0] unc_mask;
reg [31:0] cor_mask;
reg [31:0] hdr_log;
reg hdr_valid;
reg parity_err;
reg [7:0] tc_enable;
// packed read words of the resizable bar entries, one per entry
wire [31:0] resizable_bar_capability_word [0:5];

wire serial_on = cap_ctrl[`CAP_SERIAL_BIT];
wire vc_on = cap_ctrl[`CAP_VC_BIT] & serial_on;
wire vendor_on = cap_ctrl[`CAP_VENDOR_BIT] & serial_on;
wire [1:0] ecrc_mode = ecrc_ctrl[`ECRC_MODE_LSB+1:`ECRC_MODE_LSB];
wire dis_pois = ecrc_ctrl[`ECRC_DIS_POIS_BIT];
wire adv_mask = ecrc_ctrl[`ECRC_ADV_MASK_BIT];

wire wr_en = i_psel & i_penable & i_pwrite;
wire rd_en = i_psel & ~i_pwrite;
wire is_resizable_bar_capability = (i_paddr >= `ADDR_RESIZABLE_BAR_CAPABILITY_BASE) && (i_paddr < `ADDR_RESIZABLE_BAR_CAPABILITY_BASE + `RESIZABLE_BAR_CAPABILITY_SPAN);
wire [2:0] resizable_bar_capability_sel = i_paddr[4:2] - 3'h0;
// write-one-to-clear access to the event status word
wire evt_wr = wr_en && (i_paddr == `ADDR_EVT_STAT);

// ecrc check decision
function check_ecrc;
    input [1:0] mode;
    input aer_en;
    begin
        case (mode)
            `ECRC_ALWAYS: check_ecrc = 1'b1;
            `ECRC_IF_EN: check_ecrc = aer_en;
            default: check_ecrc = 1'b0;
        endcase
    end
endfunction

// single-cycle slave, always ready
assign o_pready = 1'b1;
assign o_pslverr = 1'b0;

// ==========================================================
// software writes
// ==========================================================
always @(posedge i_clk or posedge i_rst)
begin
    if (i_rst)
    begin
        cap_ctrl <= `CAP_CTRL_RESET;
        leg_ptr <= `LEG_PTR_RESET;
        ext_ptr <= `EXT_PTR_RESET;
        ecrc_ctrl <= `ECRC_CTRL_RESET;
        err_opt <= `ERR_OPT_RESET;
        unc_mask <= `MASK_RESET;
        cor_mask <= `MASK_RESET;
        tc_enable <= `TC_EN_RESET;
    end
    else if (wr_en)
    begin
        if (i_paddr == `ADDR_CAP_CTRL)
        begin
            cap_ctrl <= i_pwdata[7:0];
            tc_enable <= i_pwdata[15:8] | `TC_EN_RESET;
        end
        else if (i_paddr == `ADDR_CFG_PTR)
        begin
            if (i_pwdata[5:0] >= `LEG_PTR_MIN)
            begin
                leg_ptr <= i_pwdata[5:0];
            end
            ext_ptr <= i_pwdata[25:16];
        end
        else if (i_paddr == `ADDR_ECRC_CTRL)
        begin
            ecrc_ctrl <= i_pwdata[5:0];
        end
        else if (i_paddr == `ADDR_ERR_OPT)
        begin
            err_opt <= i_pwdata;
        end
        else if (i_paddr == `ADDR_UNC_MASK)
        begin
            unc_mask <= i_pwdata & err_opt;
        end
        else if (i_paddr == `ADDR_COR_MASK)
        begin
            cor_mask <= i_pwdata & err_opt;
        end
    end
end

// resizable bar entries, each entry keeps its own registers
genvar g;
generate
    for (g = 0; g < 6; g = g + 1)
    begin : resizable_bar_capability
        localparam [2:0] ENTRY = g;
        reg [19:0] supp_size;
        reg [2:0] bar_index;
        reg [4:0] bar_size;
        always @(posedge i_clk or posedge i_rst)
        begin
            if (i_rst)
            begin
                supp_size <= `SUPP_SIZE_RESET;
                bar_index <= ENTRY;
                bar_size <= `RESIZABLE_BAR_CAPABILITY_INIT;
            end
            else if (wr_en && is_resizable_bar_capability && (resizable_bar_capability_sel == ENTRY))
            begin
                supp_size <= i_pwdata[19:0];
                bar_index <= i_pwdata[22:20];
                bar_size <= i_pwdata[28:24];
            end
        end
        // field layout of the entry as software reads it
        assign resizable_bar_capability_word[g] = {3'h0, bar_size, 1'b0, bar_index, supp_size};
    end
endgenerate

// ==========================================================
// received tlp handling
// ==========================================================
wire legacy_hit = cap_ctrl[`CAP_LEGACY_BIT] & ~cap_ctrl[`CAP_ROOT_BIT] & ~i_rx_ext_space
    & (i_rx_dw_addr >= {4'h0, leg_ptr});
wire ext_hit = cap_ctrl[`CAP_EXT_BIT] & ~cap_ctrl[`CAP_ROOT_BIT] & i_rx_ext_space
    & (i_rx_dw_addr >= ext_ptr);
wire tc_ok = vc_on ? tc_enable[i_rx_tc] : (i_rx_tc == 3'h0);
wire snoop_rej = cap_ctrl[`CAP_ROOT_BIT] & cap_ctrl[`CAP_SNOOP_REJ_BIT]
    & i_rx_snoop_applies & ~i_rx_no_snoop;
wire pois_cfg = i_rx_valid & i_rx_poisoned & i_rx_is_cfgwr;
wire pois_mem = i_rx_valid & i_rx_poisoned & i_rx_is_memwr;
wire ecrc_fail = i_rx_valid & i_rx_td & i_rx_ecrc_bad
    & check_ecrc(ecrc_mode, ecrc_ctrl[`ECRC_AER_EN_BIT]);

// serial number copy toward the user side
always @(posedge i_clk or posedge i_rst)
begin
    if (i_rst)
    begin
        o_serial_number <= 64'h0000000000000000;
    end
    else if (serial_on)
    begin
        o_serial_number <= i_serial_number;
    end
    else
    begin
        o_serial_number <= 64'h0000000000000000;
    end
end

// routing and completion pulses, one clock after the request
always @(posedge i_clk or posedge i_rst)
begin
    if (i_rst)
    begin
        o_fwd_to_user <= 1'b0;
        o_ur_completion <= 1'b0;
        o_vc_tc <= 3'h0;
    end
    else
    begin
        o_fwd_to_user <= i_rx_valid & i_rx_is_cfg & (legacy_hit | ext_hit);
        o_ur_completion <= i_rx_valid & ((~tc_ok) | snoop_rej
            | (pois_cfg & (adv_mask | ~dis_pois)));
        if (vc_on)
        begin
            o_vc_tc <= i_rx_tc;
        end
        else
        begin
            o_vc_tc <= 3'h0;
        end
    end
end

// digest handling: check result, td pass-through and trimming
always @(posedge i_clk or posedge i_rst)
begin
    if (i_rst)
    begin
        o_ecrc_error <= 1'b0;
        o_rx_td <= 1'b0;
        o_strip_digest <= 1'b0;
    end
    else
    begin
        o_ecrc_error <= ecrc_fail;
        o_rx_td <= i_rx_td & ~ecrc_ctrl[`ECRC_TRIM_BIT];
        o_strip_digest <= i_rx_valid & i_rx_td & ecrc_ctrl[`ECRC_TRIM_BIT];
    end
end

// message: poisoned mem write automatic unless masked or disabled; user report only when disabled and not masked; ecrc failure always
always @(posedge i_clk or posedge i_rst)
begin
    if (i_rst)
    begin
        o_err_msg <= 1'b0;
    end
    else
    begin
        o_err_msg <= (pois_mem & ~adv_mask & ~dis_pois)
            | (i_poison_report & dis_pois & ~adv_mask)
            | ecrc_fail;
    end
end

// parity status on poisoned writes; set wins over clear
always @(posedge i_clk or posedge i_rst)
begin
    if (i_rst)
    begin
        parity_err <= 1'b0;
    end
    else if ((pois_cfg | pois_mem) & (adv_mask | ~dis_pois))
    begin
        parity_err <= 1'b1;
    end
    else if (evt_wr && i_pwdata[0])
    begin
        parity_err <= 1'b0;
    end
end

// single header log, first error kept until cleared
always @(posedge i_clk or posedge i_rst)
begin
    if (i_rst)
    begin
        hdr_log <= 32'h00000000;
        hdr_valid <= 1'b0;
    end
    else if ((ecrc_fail | pois_mem | pois_cfg) & ~hdr_valid)
    begin
        hdr_log <= i_rx_header;
        hdr_valid <= 1'b1;
    end
    else if (evt_wr && i_pwdata[1])
    begin
        hdr_valid <= 1'b0;
    end
end

// root status only updates with permission
always @(posedge i_clk or posedge i_rst)
begin
    if (i_rst)
    begin
        root_stat <= 32'h00000000;
        src_id <= 32'h00000000;
    end
    else if (!cap_ctrl[`CAP_ROOT_UPD_BIT])
    begin
        root_stat <= 32'h00000000;
        src_id <= 32'h00000000;
    end
    else if (ecrc_fail | pois_mem)
    begin
        root_stat <= root_stat | `ROOT_ERR_FLAG;
        src_id <= {16'h0000, i_rx_header[31:16]};
    end
end

// ==========================================================
// read data
// ==========================================================
always @*
begin
    o_prdata = 32'h00000000;
    if (rd_en)
    begin
        if (i_paddr == `ADDR_CAP_CTRL)
            o_prdata = {16'h0000, tc_enable, cap_ctrl[7:3], vendor_on, vc_on, serial_on};
        else if (i_paddr == `ADDR_CFG_PTR)
            o_prdata = {6'h00, ext_ptr, 10'h000, leg_ptr};
        else if (i_paddr == `ADDR_ECRC_CTRL)
            o_prdata = {26'h0000000, ecrc_ctrl};
        else if (i_paddr == `ADDR_ERR_OPT)
            o_prdata = err_opt;
        else if (i_paddr == `ADDR_ROOT_STAT)
            o_prdata = root_stat;
        else if (i_paddr == `ADDR_SRC_ID)
            o_prdata = src_id;
        else if (i_paddr == `ADDR_UNC_MASK)
        begin
            o_prdata = unc_mask & err_opt;
        end
        else if (i_paddr == `ADDR_COR_MASK)
        begin
            o_prdata = cor_mask & err_opt;
        end
        else if (i_paddr == `ADDR_EVT_STAT)
            o_prdata = {30'h00000000, hdr_valid, parity_err};
        else if (i_paddr == `ADDR_HDR_LOG)
            o_prdata = hdr_log;
        else if (is_resizable_bar_capability)
        begin
            o_prdata = resizable_bar_capability_word[resizable_bar_capability_sel];
        end
    end
end

endmodule

//--- rtl/ext_cap_consts.vh
`ifndef EXT_CAP_CONSTS_VH
`define EXT_CAP_CONSTS_VH

// register byte addresses
`define ADDR_CAP_CTRL 12'h000
`define ADDR_CFG_PTR 12'h004
`define ADDR_ECRC_CTRL 12'h008
`define ADDR_ERR_OPT 12'h00C
`define ADDR_ROOT_STAT 12'h010
`define ADDR_SRC_ID 12'h014
`define ADDR_UNC_MASK 12'h018
`define ADDR_COR_MASK 12'h01C
`define ADDR_EVT_STAT 12'h020
`define ADDR_HDR_LOG 12'h024
`define ADDR_RESIZABLE_BAR_CAPABILITY_BASE 12'h040

// capability control fields
`define CAP_SERIAL_BIT 0
`define CAP_VC_BIT 1
`define CAP_VENDOR_BIT 2
`define CAP_ROOT_BIT 3
`define CAP_SNOOP_REJ_BIT 4
`define CAP_LEGACY_BIT 5
`define CAP_EXT_BIT 6
`define CAP_ROOT_UPD_BIT 7
`define CAP_CTRL_RESET 8'h00

// ecrc control fields
`define ECRC_MODE_LSB 0
`define ECRC_AER_EN_BIT 2
`define ECRC_TRIM_BIT 3
`define ECRC_DIS_POIS_BIT 4
`define ECRC_ADV_MASK_BIT 5
`define ECRC_CTRL_RESET 6'h20

`define ECRC_NEVER 2'h0
`define ECRC_ALWAYS 2'h1
`define ECRC_RSVD 2'h2
`define ECRC_IF_EN 2'h3

// config space pointers
`define LEG_PTR_MIN 6'h2A
`define LEG_PTR_MAX 6'h3F
`define LEG_PTR_RESET 6'h3F
`define EXT_PTR_RESET 10'h043
`define SUPP_SIZE_RESET 20'h00001
`define RESIZABLE_BAR_CAPABILITY_INIT 5'h00
`define RESIZABLE_BAR_CAPABILITY_SPAN 12'h018

// status and mask reset values
`define ERR_OPT_RESET 32'hFFFFFFFF
`define MASK_RESET 32'h00000000
`define TC_EN_RESET 8'h01
`define ROOT_ERR_FLAG 32'h00000004

`endif

//--- test/ext_cap_config_props.sv
`timescale 1ns/1ps
// ========================================
// port checker for the capability block
module ext_cap_config_props
(
    input wire i_clk,
    input wire i_rst,
    input wire i_rx_valid,
    input wire i_rx_is_cfg,
    input wire i_rx_is_memwr,
    input wire i_rx_poisoned,
    input wire i_rx_ecrc_bad,
    input wire i_rx_snoop_applies,
    input wire [2:0] i_rx_tc,
    input wire i_poison_report,
    input wire [63:0] i_serial_number,
    input wire o_fwd_to_user,
    input wire o_ur_completion,
    input wire o_ecrc_error,
    input wire o_rx_td,
    input wire o_strip_digest,
    input wire o_err_msg,
    input wire [63:0] o_serial_number
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    // each pulse is tied to its cause one cycle before, except strip, checked against td in the same cycle
    property p_strip; o_strip_digest |-> !o_rx_td; endproperty
    a_strip: assert property (p_strip) else $error("digest stripped, td kept");
    property p_ecrc; o_ecrc_error |-> $past(i_rx_valid && i_rx_ecrc_bad); endproperty
    a_ecrc: assert property (p_ecrc) else $error("ecrc error without bad tlp");
    property p_fwd; o_fwd_to_user |-> $past(i_rx_valid && i_rx_is_cfg); endproperty
    a_fwd: assert property (p_fwd) else $error("forward without cfg request");
    property p_sn; o_serial_number != 64'h0 |-> o_serial_number == $past(i_serial_number);
    endproperty
    a_sn: assert property (p_sn) else $error("serial number copy wrong");
    property p_ur; o_ur_completion |-> $past(i_rx_valid); endproperty
    a_ur: assert property (p_ur) else $error("ur without request");
    property p_msg; o_err_msg |-> $past(i_rx_valid || i_poison_report); endproperty
    a_msg: assert property (p_msg) else $error("error message without cause");
    property p_mw;
        i_rx_valid && i_rx_poisoned && i_rx_is_memwr && i_rx_tc == 3'h0
            && !i_rx_snoop_applies |=> !o_ur_completion;
    endproperty
    a_mw: assert property (p_mw) else $error("poisoned write answered");
    property p_quiet;
        i_rx_valid && !i_rx_poisoned && !i_rx_ecrc_bad && !i_poison_report |=> !o_err_msg;
    endproperty
    a_quiet: assert property (p_quiet) else $error("unexpected error message");
    c_fwd: cover property (o_fwd_to_user);
    c_msg: cover property (o_err_msg);
    c_strip: cover property (o_strip_digest);
    c_ur: cover property (o_ur_completion);
endmodule

bind ext_cap_config ext_cap_config_props i_props (.i_clk, .i_rst, .i_rx_valid, .i_rx_is_cfg,
    .i_rx_is_memwr, .i_rx_poisoned, .i_rx_ecrc_bad, .i_rx_snoop_applies, .i_rx_tc,
    .i_poison_report, .i_serial_number, .o_fwd_to_user, .o_ur_completion, .o_ecrc_error,
    .o_rx_td, .o_strip_digest, .o_err_msg, .o_serial_number);

//--- test/link_partner_model.sv
`timescale 1ns/1ps
// ========================================
// link partner: one received tlp per call
module link_partner_model
(
    input wire i_clk,
    output reg o_valid,
    output reg [6:0] o_kind,
    output reg [9:0] o_dw_addr,
    output reg [31:0] o_header
);
    // idle values before the first tlp
    initial
    begin
        o_valid = 1'b0;
        o_kind = 7'h00;
        o_dw_addr = 10'h000;
        o_header = 32'h00000000;
    end
    // tlp valid one cycle, then qualifiers show junk
    task send(input [6:0] kind, input [9:0] addr, input [31:0] hdr);
    begin
        @(posedge i_clk);
        o_valid <= 1'b1;
        o_kind <= kind;
        o_dw_addr <= addr;
        o_header <= hdr;
        @(posedge i_clk);
        o_valid <= 1'b0;
        o_kind <= ~kind;
        o_dw_addr <= ~addr;
        o_header <= ~hdr;
    end
    endtask
endmodule

//--- test/ext_cap_config_tb.sv
`timescale 1ns/1ps
`include "ext_cap_consts.vh"
// ========================================
// bench: kind bits cfg,cfgwr,memwr,ext,td,poisoned,ecrc_bad
module ext_cap_config_tb;
    reg i_clk = 1'b0;
    reg i_rst = 1'b1;
    reg psel = 1'b0, penable = 1'b0, pwrite = 1'b0, poison_report = 1'b0;
    reg [11:0] paddr = 12'h000;
    reg [31:0] pwdata = 32'h00000000;
    reg [31:0] rd;
    reg [63:0] serial = 64'h0123456789ABCDEF;
    reg [2:0] tc = 3'h0;
    reg snoop_app = 1'b0, no_snoop = 1'b0;
    wire pready, pslverr, v, fwd, ur, ecrc_err, rx_td, strip, msg;
    wire [6:0] k;
    wire [9:0] dw;
    wire [31:0] prdata, hdr;
    wire [2:0] vc_tc;
    wire [63:0] serial_q;
    integer mismatches = 0;
    integer check_count = 0;
    integer m;
    // clock
    always #25 i_clk = ~i_clk;
    link_partner_model i_model (.i_clk(i_clk), .o_valid(v), .o_kind(k), .o_dw_addr(dw),
        .o_header(hdr));
    ext_cap_config i_dut (.i_clk(i_clk), .i_rst(i_rst), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready),
        .o_prdata(prdata), .o_pslverr(pslverr), .i_serial_number(serial), .i_rx_valid(v),
        .i_rx_is_cfg(k[6]), .i_rx_is_cfgwr(k[5]), .i_rx_is_memwr(k[4]),
        .i_rx_ext_space(k[3]), .i_rx_dw_addr(dw), .i_rx_tc(tc), .i_rx_snoop_applies(snoop_app),
        .i_rx_no_snoop(no_snoop), .i_rx_td(k[2]), .i_rx_poisoned(k[1]), .i_rx_ecrc_bad(k[0]),
        .i_rx_header(hdr), .i_poison_report(poison_report), .o_fwd_to_user(fwd),
        .o_ur_completion(ur), .o_ecrc_error(ecrc_err), .o_rx_td(rx_td),
        .o_strip_digest(strip), .o_err_msg(msg), .o_vc_tc(vc_tc), .o_serial_number(serial_q));
    // shared compare
    task chk(input [63:0] got, input [63:0] exp);
    begin
        check_count = check_count + 1;
        if (got !== exp)
        begin
            mismatches = mismatches + 1;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    end
    endtask
    // one apb transfer, held until pready
    task apb(input wr, input [11:0] a, input [31:0] d);
    begin
        @(posedge i_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge i_clk);
        penable <= 1'b1;
        @(posedge i_clk);
        while (pready !== 1'b1)
            @(posedge i_clk);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    end
    endtask
    // tlp then look at the pulse cycle
    task tlp(input [6:0] kind, input [9:0] a, input [31:0] h);
    begin
        i_model.send(kind, a, h);
        #1;
    end
    endtask
    // tlp attributes, changed on a rising edge before the next tlp
    task rx_attr(input [2:0] t, input s, input n);
    begin
        @(posedge i_clk);
        tc <= t;
        snoop_app <= s;
        no_snoop <= n;
    end
    endtask
    task t_regs;
    begin
        apb(0, `ADDR_CFG_PTR, 0); chk(rd, 32'h0043003F);
        chk({pready, pslverr}, 2'b10);
        apb(0, `ADDR_RESIZABLE_BAR_CAPABILITY_BASE, 0); chk(rd, 32'h00000001);
        apb(0, `ADDR_RESIZABLE_BAR_CAPABILITY_BASE + 12'h004, 0); chk(rd, 32'h00100001);
        apb(1, `ADDR_ERR_OPT, 0);
        apb(1, `ADDR_UNC_MASK, 32'hFFFFFFFF);
        apb(0, `ADDR_UNC_MASK, 0); chk(rd, 0);
        apb(1, 12'h030, 32'hFFFFFFFF);
        apb(0, 12'h030, 0); chk(rd, 0);
        $display("registers done");
    end
    endtask
    task t_serial;
    begin
        apb(1, `ADDR_CAP_CTRL, 32'h6);
        apb(0, `ADDR_CAP_CTRL, 0); chk(rd & 32'h7, 0);
        apb(1, `ADDR_CAP_CTRL, 32'h7);
        apb(0, `ADDR_CAP_CTRL, 0); chk(rd & 32'h7, 32'h7);
        chk(serial_q, serial);
        $display("serial done");
    end
    endtask
    task t_fwd;
    begin
        apb(1, `ADDR_CAP_CTRL, 32'h41);
        apb(1, `ADDR_CFG_PTR, 32'h01000029);
        apb(0, `ADDR_CFG_PTR, 0); chk(rd, 32'h0100003F);
        tlp(7'h48, 10'h100, 0); chk(fwd, 1);
        tlp(7'h48, 10'h0FF, 0); chk(fwd, 0);
        apb(1, `ADDR_CAP_CTRL, 32'h21);
        apb(1, `ADDR_CFG_PTR, 32'h0100002A);
        tlp(7'h40, 10'h02A, 0); chk(fwd, 1);
        tlp(7'h40, 10'h010, 0); chk(fwd, 0);
        $display("forwarding done");
    end
    endtask
    task t_ecrc;
    begin
        for (m = 0; m < 4; m = m + 1)
        begin
            apb(1, `ADDR_ECRC_CTRL, m);
            tlp(7'h15, 0, 0); chk(ecrc_err, m == 1);
        end
        apb(1, `ADDR_ECRC_CTRL, 32'h7);
        tlp(7'h15, 0, 0); chk(ecrc_err, 1);
        apb(1, `ADDR_ECRC_CTRL, 32'h8);
        tlp(7'h14, 0, 0); chk({rx_td, strip}, 2'b01);
        apb(1, `ADDR_ECRC_CTRL, 32'h0);
        tlp(7'h14, 0, 0); chk({rx_td, strip}, 2'b10);
        $display("ecrc done");
    end
    endtask
    task t_poison;
    begin
        apb(1, `ADDR_ECRC_CTRL, 32'h20);
        apb(1, `ADDR_EVT_STAT, 32'h3);
        tlp(7'h62, 10'h004, 32'hAAAA0001); chk({ur, msg}, 2'b10);
        tlp(7'h12, 0, 32'hBBBB0002); chk({ur, msg}, 2'b00);
        apb(0, `ADDR_EVT_STAT, 0); chk(rd & 32'h1, 1);
        apb(0, `ADDR_HDR_LOG, 0); chk(rd, 32'hAAAA0001);
        apb(0, `ADDR_ROOT_STAT, 0); chk(rd, 0);
        apb(1, `ADDR_ECRC_CTRL, 32'h0);
        tlp(7'h12, 0, 0); chk(msg, 1);
        apb(1, `ADDR_ECRC_CTRL, 32'h10);
        tlp(7'h12, 0, 0); chk(msg, 0);
        @(posedge i_clk);
        poison_report <= 1'b1;
        @(posedge i_clk);
        poison_report <= 1'b0;
        #1 chk(msg, 1);
        $display("poisoned done");
    end
    endtask
    task t_vc;
    begin
        apb(1, `ADDR_CAP_CTRL, 32'h0503);
        rx_attr(3'h2, 0, 0);
        tlp(7'h10, 0, 0); chk({ur, vc_tc}, 4'h2);
        rx_attr(3'h1, 0, 0);
        tlp(7'h10, 0, 0); chk({ur, vc_tc}, 4'h9);
        apb(1, `ADDR_CAP_CTRL, 32'h19);
        rx_attr(3'h0, 1, 0);
        tlp(7'h10, 0, 0); chk(ur, 1);
        rx_attr(3'h0, 1, 1);
        tlp(7'h10, 0, 0); chk(ur, 0);
        rx_attr(3'h0, 0, 0);
        apb(1, `ADDR_CAP_CTRL, 32'h81);
        tlp(7'h12, 0, 32'h12340000);
        apb(0, `ADDR_ROOT_STAT, 0); chk(rd, 32'h4);
        apb(0, `ADDR_SRC_ID, 0); chk(rd, 32'h1234);
        apb(1, `ADDR_CAP_CTRL, 32'h1);
        apb(0, `ADDR_SRC_ID, 0); chk(rd, 0);
        $display("channel and root done");
    end
    endtask
    task test_done;
    begin
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    end
    endtask
    // main sequence
    initial
    begin
        repeat (2) @(posedge i_clk);
        i_rst <= 1'b0;
        t_regs;
        t_serial;
        t_fwd;
        t_ecrc;
        t_poison;
        t_vc;
        test_done;
    end
    // watchdog
    initial
    begin
        #200000;
        mismatches = mismatches + 1;
        test_done;
    end
endmodule
